// ===== mbag_pkg.sv
// package: constants, types and register map of the address generator
//
// Contract
// - modulo usable on any selected working register
// - wrap on crossing boundary, not only equality
// - write back wrapped address on pre/post modify
// - offset mode wraps address, pointer unchanged
// - reversal only in x unit, writes only
// - only modifier reversed; pointer in normal order
// - reversal needs select not 15, enable, pre/post increment
// - fifteen-bit modifier is the pivot point
// - reversed addresses word sized, modifier scaled
// - other modes or bytes give normal addresses
// - reversal adds modifier, ignores increment, clears bit0
// - reversal beats x write modulo; x read keeps
// - sixteen-entry buffer gives bit-mirrored index order
// - x modulo needs select not 15, enable bit15
// - y modulo needs select not 15, enable bit14
// - buffer length from 16-bit start/end registers
package mbag_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_MOD_CTRL = 8'h00;
   localparam logic [7:0] OFS_BREV_CTRL = 8'h04;
   localparam logic [7:0] OFS_XMOD_START = 8'h08;
   localparam logic [7:0] OFS_XMOD_END = 8'h0c;
   localparam logic [7:0] OFS_YMOD_START = 8'h10;
   localparam logic [7:0] OFS_YMOD_END = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int X_MODULO_ENABLE_BIT = 15;
   localparam int Y_MODULO_ENABLE_BIT = 14;
   localparam int BITREV_ENABLE_BIT = 15;
   localparam int XSEL_LSB = 0;
   localparam int YSEL_LSB = 4;
   localparam int BSEL_LSB = 8;
   localparam logic [3:0] SEL_NONE = 4'hf;
   localparam logic [15:0] MOD_CTRL_RST = 16'h0fff;
   localparam logic [15:0] BREV_CTRL_RST = 16'h0000;
   localparam logic [15:0] BOUND_RST = 16'h0000;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      AM_INDIRECT, AM_POST_INC, AM_POST_DEC, AM_PRE_INC, AM_PRE_DEC,
      AM_OFFSET
   } mbag_mode_e;
   typedef enum logic [1:0] {
      UNIT_X_READ, UNIT_X_WRITE, UNIT_Y
   } mbag_unit_e;
   typedef struct packed {
      logic valid;
      mbag_unit_e unit;
      mbag_mode_e mode;
      logic byte_sz;
      logic [3:0] wreg;
      logic [15:0] ptr;
      logic [15:0] step;
   } mbag_req_s;
   typedef struct packed {
      logic valid;
      logic [15:0] ea;
      logic wb_en;
      logic [3:0] wb_reg;
      logic [15:0] wb_val;
      logic brev;
      logic wrapped;
   } mbag_rsp_s;
endpackage

// ===== mbag_top.sv
// module: modulo and bit-reversed effective address generator
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module mbag_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pipeline request and answer
   input wire mbag_pkg::mbag_req_s req,
   output mbag_pkg::mbag_rsp_s rsp
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] mod_ctrl;
      logic [15:0] brev_ctrl;
      logic [15:0] xstart;
      logic [15:0] xend;
      logic [15:0] ystart;
      logic [15:0] yend;
      logic [15:0] wraps;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      mbag_pkg::mbag_rsp_s rsp;
   } mbag_state_s;

   mbag_state_s st_q, st_d;

   // mirror a 15-bit value end for end
   function automatic logic [14:0] mbag_mirror(input logic [14:0] v);
      logic [14:0] r;
      r = '0;
      for (int i = 0; i < 15; i++) begin
         r[i] = v[14-i];
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // decode of the current request
   // ---------------------------------------------------------------
   logic [3:0] xsel, ysel, bsel;
   logic xmod_on, ymod_on, brev_on;
   logic is_pre, is_post, is_inc, is_mod_mode;
   logic [15:0] base, ea_raw, ea_wrap, ea_out, lo, hi;
   logic mod_hit, wrap_hi, wrap_lo;
   logic [14:0] mod_rev, sum_rev;
   logic [15:0] brev_ea;
   logic [15:0] buf_len;

   always_comb begin
      xsel = st_q.mod_ctrl[mbag_pkg::XSEL_LSB +: 4];
      ysel = st_q.mod_ctrl[mbag_pkg::YSEL_LSB +: 4];
      bsel = st_q.mod_ctrl[mbag_pkg::BSEL_LSB +: 4];
      // x modulo: select not 15 and enable bit 15
      xmod_on = (xsel != mbag_pkg::SEL_NONE)
                && st_q.mod_ctrl[mbag_pkg::X_MODULO_ENABLE_BIT];
      ymod_on = (ysel != mbag_pkg::SEL_NONE)
                && st_q.mod_ctrl[mbag_pkg::Y_MODULO_ENABLE_BIT];
      is_pre = (req.mode == mbag_pkg::AM_PRE_INC)
               || (req.mode == mbag_pkg::AM_PRE_DEC);
      is_post = (req.mode == mbag_pkg::AM_POST_INC)
                || (req.mode == mbag_pkg::AM_POST_DEC);
      is_inc = (req.mode == mbag_pkg::AM_PRE_INC)
               || (req.mode == mbag_pkg::AM_POST_INC);
      is_mod_mode = is_pre || is_post;
      // reversal only for x writes, words, increment modes
      brev_on = (bsel != mbag_pkg::SEL_NONE)
                && st_q.brev_ctrl[mbag_pkg::BITREV_ENABLE_BIT]
                && (req.unit == mbag_pkg::UNIT_X_WRITE)
                && !req.byte_sz && is_inc
                && (req.wreg == bsel);
      // modified address: pre/offset use the sum, post the unmodified pointer
      ea_raw = req.ptr + req.step;
      base = (is_pre || req.mode == mbag_pkg::AM_OFFSET) ? ea_raw : req.ptr;
      // pick the circular buffer of this unit
      lo = (req.unit == mbag_pkg::UNIT_Y) ? st_q.ystart : st_q.xstart;
      hi = (req.unit == mbag_pkg::UNIT_Y) ? st_q.yend : st_q.xend;
      buf_len = 16'(hi - lo + 16'h0001);
      // any register but 15 may be the pointer; reversal kills x write modulo
      mod_hit = ((req.unit == mbag_pkg::UNIT_Y) ? (ymod_on
                && req.wreg == ysel) : (xmod_on && req.wreg == xsel))
                && !brev_on;
      // crossing, not only equality, triggers the wrap
      wrap_hi = mod_hit && (ea_raw > hi) && (req.ptr <= hi);
      wrap_lo = mod_hit && (ea_raw < lo) && (req.ptr >= lo);
      ea_wrap = wrap_hi ? 16'(ea_raw - buf_len)
              : wrap_lo ? 16'(ea_raw + buf_len) : ea_raw;
      // reversed carry add: pointer word index mirrored, modifier added
      // reversed, mirrored back; pointer keeps normal order
      mod_rev = mbag_mirror(st_q.brev_ctrl[14:0]);
      sum_rev = 15'(mbag_mirror(req.ptr[15:1]) + mod_rev);
      brev_ea = {mbag_mirror(sum_rev), 1'b0};
      ea_out = (is_pre || req.mode == mbag_pkg::AM_OFFSET)
               ? ((wrap_hi || wrap_lo) ? ea_wrap : ea_raw) : base;
   end

   // ---------------------------------------------------------------
   // next state: registers, bus and address answer
   // ---------------------------------------------------------------
   logic bus_go;
   always_comb begin
      st_d = st_q;
      bus_go = hsel && hready && htrans[1];
      // write data phase lands one cycle after the address phase
      if (st_q.wr_pend) begin
         unique case (st_q.wr_addr)
            mbag_pkg::OFS_MOD_CTRL: st_d.mod_ctrl = hwdata[15:0];
            mbag_pkg::OFS_BREV_CTRL: st_d.brev_ctrl = hwdata[15:0];
            mbag_pkg::OFS_XMOD_START: st_d.xstart = hwdata[15:0];
            mbag_pkg::OFS_XMOD_END: st_d.xend = hwdata[15:0];
            mbag_pkg::OFS_YMOD_START: st_d.ystart = hwdata[15:0];
            mbag_pkg::OFS_YMOD_END: st_d.yend = hwdata[15:0];
            default: ;
         endcase
      end
      st_d.wr_pend = bus_go && hwrite;
      st_d.wr_addr = haddr;
      if (bus_go && !hwrite) begin
         unique case (haddr)
            mbag_pkg::OFS_MOD_CTRL: st_d.rdata = {16'h0000, st_q.mod_ctrl};
            mbag_pkg::OFS_BREV_CTRL: st_d.rdata = {16'h0000, st_q.brev_ctrl};
            mbag_pkg::OFS_XMOD_START: st_d.rdata = {16'h0000, st_q.xstart};
            mbag_pkg::OFS_XMOD_END: st_d.rdata = {16'h0000, st_q.xend};
            mbag_pkg::OFS_YMOD_START: st_d.rdata = {16'h0000, st_q.ystart};
            mbag_pkg::OFS_YMOD_END: st_d.rdata = {16'h0000, st_q.yend};
            mbag_pkg::OFS_STATUS: st_d.rdata = {16'h0000, st_q.wraps};
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
      // wrap counter shows the number of modulo wraps to software
      if (req.valid && (wrap_hi || wrap_lo)) begin
         st_d.wraps = 16'(st_q.wraps + 16'h0001);
      end
      // answer: one cycle after the request
      st_d.rsp.valid = req.valid;
      st_d.rsp.brev = req.valid && brev_on;
      st_d.rsp.wrapped = req.valid && (wrap_hi || wrap_lo);
      st_d.rsp.wb_reg = req.wreg;
      st_d.rsp.ea = brev_on ? brev_ea : ea_out;
      // pointer writeback only for pre/post modify
      st_d.rsp.wb_en = req.valid && (is_mod_mode || brev_on);
      st_d.rsp.wb_val = brev_on ? brev_ea
                       : (wrap_hi || wrap_lo) ? ea_wrap : ea_raw;
   end

   // state register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
         st_q.mod_ctrl <= mbag_pkg::MOD_CTRL_RST;
         st_q.brev_ctrl <= mbag_pkg::BREV_CTRL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // data and answer straight from flip-flops; ready and response tied off; zero wait states
   assign hrdata = st_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rsp = st_q.rsp;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_offset_no_wb: assert property (@(posedge mclk) disable iff (!rst_b)
      req.valid && req.mode == mbag_pkg::AM_OFFSET && !brev_on
      |=> !rsp.wb_en) else $error("offset mode wrote pointer");
   chk_brev_bit0: assert property (@(posedge mclk) disable iff (!rst_b)
      req.valid && brev_on |=> rsp.ea[0] == 1'b0 && rsp.brev)
      else $error("reversed address bit0 set");
   chk_brev_xwrite: assert property (@(posedge mclk) disable iff (!rst_b)
      rsp.brev |-> $past(req.unit) == mbag_pkg::UNIT_X_WRITE
      && !$past(req.byte_sz)) else $error("reversal off x write");
   chk_brev_beats_mod: assert property (@(posedge mclk) disable iff (!rst_b)
      rsp.brev |-> !rsp.wrapped) else $error("modulo with reversal");
   chk_xmod_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      rsp.wrapped && $past(req.unit) != mbag_pkg::UNIT_Y
      |-> $past(st_q.mod_ctrl[15]) && $past(xsel) != 4'hf)
      else $error("x wrap while disabled");
   chk_ymod_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      rsp.wrapped && $past(req.unit) == mbag_pkg::UNIT_Y
      |-> $past(st_q.mod_ctrl[14]) && $past(ysel) != 4'hf)
      else $error("y wrap while disabled");
   // a wrapped pointer must land back inside the buffer bounds
   chk_wrap_in_buf: assert property (@(posedge mclk) disable iff (!rst_b)
      req.valid && (wrap_hi || wrap_lo) && is_mod_mode
      |=> rsp.wb_val >= $past(lo) && rsp.wb_val <= $past(hi))
      else $error("wrapped pointer outside buffer");
   chk_mod_wb: assert property (@(posedge mclk) disable iff (!rst_b)
      req.valid && is_mod_mode |=> rsp.wb_en && rsp.valid)
      else $error("modify mode without writeback");
   chk_brev_step: assert property (@(posedge mclk) disable iff (!rst_b)
      req.valid && brev_on && req.ptr[4:0] == 5'h00
      && st_q.brev_ctrl[14:0] == 15'h0008
      |=> rsp.ea == 16'($past(req.ptr) + 16'h0010))
      else $error("reversed step wrong");
   cov_brev: cover property (@(posedge mclk) disable iff (!rst_b) rsp.brev);
   cov_wrap_hi: cover property (@(posedge mclk) disable iff (!rst_b)
      req.valid && wrap_hi);
   cov_wrap_lo: cover property (@(posedge mclk) disable iff (!rst_b)
      req.valid && wrap_lo);
endmodule

// ===== mbag_pipe_model.sv
// partner model: pipeline stage that hands requests to the generator
`timescale 1ns/1ps
module mbag_pipe_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // request from the sequencer, request to the generator
   input wire mbag_pkg::mbag_req_s cmd,
   output mbag_pkg::mbag_req_s req
);
   // one stage; cleared in reset so no stray valid leaks out
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req <= '0;
      end else begin
         req <= cmd;
      end
   end
endmodule

// ===== tb_top.sv
// testbench: bus access and random requests against a reference model
`timescale 1ns/1ps
module tb_top;
   // ---------------------------------------------------------------
   // bench state
   // ---------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp;
   mbag_pkg::mbag_req_s cmd = '0;
   mbag_pkg::mbag_req_s req, q;
   mbag_pkg::mbag_rsp_s rsp, got;
   int err_total = 0;
   int checks_done = 0;
   int wraps_exp = 0;
   logic [31:0] seed = 32'd91056;
   logic [15:0] mc, bc;
   logic [15:0] bnd [4] = '{16'h1000, 16'h101f, 16'h2000, 16'h203f};
   // plain, reversal, shared pointer, modulo off, selects at 15
   logic [15:0] cmc [5] = '{16'hc453, 16'hc453, 16'hc343, 16'h0453, 16'hcfff};
   logic [15:0] cbc [5] = '{16'h0008, 16'h8004, 16'h8010, 16'h8008, 16'h8001};
   // free-running core clock
   always #10 mclk = ~mclk;
   mbag_pipe_model pm (.mclk(mclk), .rst_b(rst_b), .cmd(cmd), .req(req));
   mbag_top dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .req(req), .rsp(rsp));
   // ---------------------------------------------------------------
   // tasks and reference model
   // ---------------------------------------------------------------
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [14:0] mirror15(input logic [14:0] v);
      logic [14:0] m;
      for (int i = 0; i < 15; i++) m[i] = v[14 - i];
      return m;
   endfunction
   // bounded wait; hready is sampled at each rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         err_total++;
         print_verdict();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [15:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {16'h0, d};
      wait_rdy();
      rd = hrdata;
      chk(40'(hresp), 40'h0);
   endtask
   function automatic mbag_pkg::mbag_rsp_s model(mbag_pkg::mbag_req_s r);
      mbag_pkg::mbag_rsp_s e;
      logic y, on, br;
      int s, t, raw;
      y = r.unit == mbag_pkg::UNIT_Y;
      s = y ? bnd[2] : bnd[0];
      t = y ? bnd[3] : bnd[1];
      br = r.wreg == mc[11:8] && mc[11:8] != 4'hf && bc[15] && !r.byte_sz
         && r.unit == mbag_pkg::UNIT_X_WRITE && (r.mode ==
         mbag_pkg::AM_POST_INC || r.mode == mbag_pkg::AM_PRE_INC);
      on = (y ? mc[14] : mc[15]) && r.wreg == (y ? mc[7:4] : mc[3:0])
         && r.wreg != 4'hf && !br;
      raw = 16'(r.ptr + r.step);
      e = '0;
      e.valid = 1'b1;
      if (on && raw > t && r.ptr <= t) begin
         raw = raw - (t - s + 1);
         e.wrapped = 1'b1;
      end else if (on && raw < s && r.ptr >= s) begin
         raw = raw + (t - s + 1);
         e.wrapped = 1'b1;
      end
      e.wb_val = 16'(raw);
      e.wb_reg = r.wreg;
      e.ea = r.mode >= mbag_pkg::AM_PRE_INC ? e.wb_val : r.ptr;
      e.wb_en = r.mode != mbag_pkg::AM_INDIRECT
         && r.mode != mbag_pkg::AM_OFFSET;
      if (br) begin
         e.brev = 1'b1;
         e.wb_en = 1'b1;
         e.ea = {mirror15(mirror15(r.ptr[15:1]) + mirror15(bc[14:0])), 1'b0};
         e.wb_val = e.ea;
      end
      return e;
   endfunction
   function automatic mbag_pkg::mbag_req_s mkreq();
      mbag_pkg::mbag_req_s n;
      logic [31:0] r;
      r = rnd();
      n.valid = 1'b1;
      n.unit = mbag_pkg::mbag_unit_e'(r[1:0] % 2'd3);
      n.mode = mbag_pkg::mbag_mode_e'(r[4:2] % 3'd6);
      n.byte_sz = r[5] & r[6];
      n.wreg = 4'h3 + {2'h0, r[8:7]};
      n.ptr = bnd[r[1:0] == 2'd2 ? 2 : 0] + {11'h0, r[12:9], 1'b0};
      n.step = n.mode == mbag_pkg::AM_INDIRECT ? 16'h0 :
         {{12{r[16]}}, r[15:13], 1'b0};
      return n;
   endfunction
   // one request through the pipe stage; answer one cycle after take
   task automatic issue(input mbag_pkg::mbag_req_s r);
      int n;
      logic [39:0] m;
      mbag_pkg::mbag_rsp_s e;
      e = model(r);
      if (e.wrapped) wraps_exp++;
      m = e.wb_en ? '1 : 40'hffffc00003;
      cmd <= r;
      @(posedge mclk);
      cmd.valid <= 1'b0;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (rsp.valid !== 1'b1 && n < 8);
      got = rsp;
      if (got.valid !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      chk(got & m, e & m);
      @(posedge mclk);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         ahb(1'b0, 8'(i * 4), 16'h0);
         chk(40'(rd), i == 0 ? 40'h0fff : 40'h0);
      end
      ahb(1'b1, 8'h1c, 16'hffff);
      ahb(1'b0, 8'h1c, 16'h0);
      chk(40'(rd), 40'h0);
      for (int k = 0; k < 4; k++) begin
         ahb(1'b1, 8'h08 + 8'(k * 4), bnd[k]);
         ahb(1'b0, 8'h08 + 8'(k * 4), 16'h0);
         chk(40'(rd), 40'(bnd[k]));
      end
      for (int c = 0; c < 5; c++) begin
         mc = cmc[c];
         bc = cbc[c];
         ahb(1'b1, mbag_pkg::OFS_MOD_CTRL, mc);
         ahb(1'b1, mbag_pkg::OFS_BREV_CTRL, bc);
         ahb(1'b0, mbag_pkg::OFS_BREV_CTRL, 16'h0);
         chk(40'(rd), 40'(bc));
         repeat (2) @(posedge mclk);
         for (int i = 0; i < 40; i++) issue(mkreq());
      end
      // 16-word buffer, pivot half its size, start on a 32-byte line
      mc = 16'h0453;
      bc = 16'h8008;
      ahb(1'b1, mbag_pkg::OFS_MOD_CTRL, mc);
      ahb(1'b1, mbag_pkg::OFS_BREV_CTRL, bc);
      q = mkreq();
      q.unit = mbag_pkg::UNIT_X_WRITE;
      q.mode = mbag_pkg::AM_POST_INC;
      q.byte_sz = 1'b0;
      q.wreg = 4'h4;
      q.ptr = 16'h0800;
      for (int i = 1; i <= 16; i++) begin
         issue(q);
         chk(40'(got.ea), 40'(32'h800 + 2 * (mirror15(15'(i % 16)) >> 11)));
         q.ptr = got.wb_val;
      end
      // wrap counter must match every correction the model expected
      ahb(1'b0, mbag_pkg::OFS_STATUS, 16'h0);
      chk(40'(rd), 40'(16'(wraps_exp)));
      print_verdict();
   end
endmodule
